//--- logic/lfp_pkg.sv
/*
  Package for the shared pin control of the low-frequency receive front end.
  Holds output type codes, reset values and timing constants.
  Assumes a 10 MHz core clock.
*/
package lfp_pkg;

  // Output type selection codes.
  typedef enum logic [1:0] {
    LFP_OUT_DEMOD,
    LFP_OUT_CARRIER,
    LFP_OUT_STRENGTH
  } lfp_out_type_t;

  // Core clock rate in hertz.
  localparam int CORE_CLK_HZ = 10000000;

  // Alarm timer, in milliseconds, and its cycle count.
  localparam int ALARM_MS = 32;
  localparam int ALARM_CYC = ALARM_MS * (CORE_CLK_HZ / 1000);

  // Gain settle time in microseconds; a plain default, converted to cycles, at least one.
  localparam int GAIN_SETTLE_US = 1000;
  localparam int GAIN_SETTLE_CYC = (GAIN_SETTLE_US * (CORE_CLK_HZ / 1000000) > 0) ?
                                   GAIN_SETTLE_US * (CORE_CLK_HZ / 1000000) : 1;

  // Least high time that opens the output enable filter, in microseconds.
  localparam int OE_HIGH_US = 500;
  localparam int OE_HIGH_CYC = (OE_HIGH_US * (CORE_CLK_HZ / 1000000) > 0) ?
                               OE_HIGH_US * (CORE_CLK_HZ / 1000000) : 1;

  // Configuration register file shape and reset value of each row.
  localparam int CFG_ROWS = 8;
  localparam int CFG_ROW_W = 9;
  localparam int CFG_IDX_W = 3;
  localparam logic [8:0] CFG_ROW_RST = 9'h100;

  // Width of the long timers.
  localparam int TMR_W = 20;
  localparam logic [19:0] TMR_ZERO = 20'h00000;

endpackage

//--- logic/lfp_shared_pin_ctrl.sv
/*
  Shared digital pin control of a three-channel low-frequency receive front end.
  Chip select picks receive operation or serial programming; one pin is serial
  clock or open-collector alert, another is data, carrier square or serial data.
  Assumes pins are asynchronous to core_clk and are sampled through two flops,
  and that configuration writes and output selects come from core_clk logic.
*/
`timescale 1ns/1ps
module lfp_shared_pin_ctrl
  import lfp_pkg::*;
#(
  parameter int ALARM_CYCLES = ALARM_CYC,
  parameter int SETTLE_CYCLES = GAIN_SETTLE_CYC,
  parameter int OE_HIGH_CYCLES = OE_HIGH_CYC
) (
  input wire logic core_clk, // Core clock, 10 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic clk_en, // Clock enable; all state but the reset synchroniser holds while low.
  input wire logic chip_sel_n_pin, // Chip select pin, active low.
  input wire logic sclk_alert_i, // Clock/alert pin level.
  output logic sclk_alert_o, // Clock/alert pin drive value.
  output logic sclk_alert_oe, // Clock/alert pin pulls low while high.
  input wire logic data_pin_i, // Data pin level.
  output logic data_pin_o, // Data pin drive value.
  output logic data_pin_oe, // Data pin driven while high.
  input wire logic demod_raw, // Demodulator output from the analog path.
  input wire logic carrier_raw, // Squared input carrier from the analog path.
  input wire lfp_out_type_t out_type_sel, // Output type selection.
  input wire logic oe_filter_en, // Output enable filter enable.
  input wire logic inact_expired, // Inactivity timer expiry pulse.
  input wire logic cfg_wr, // Configuration row write strobe.
  input wire logic [2:0] cfg_wr_idx, // Configuration row index.
  input wire logic [8:0] cfg_wr_data, // Configuration row data with parity.
  input wire logic serial_tx_en, // Device read data is to be driven.
  input wire logic serial_tx_bit, // Next read data bit.
  output logic serial_rx_bit, // Last serial bit taken in.
  output logic serial_rx_valid, // One-cycle pulse per serial bit taken.
  output logic signal_strength_out, // Signal strength current sink enable.
  output logic parity_err, // Some configuration row has bad parity.
  output logic alarm_expired, // Alarm timer has run out.
  output logic recv_mode // Receive mode, chip select high.
);

  logic [1:0] rst_sync_r;
  logic rst_int_n;
  logic cs_s1_r, cs_s2_r, sclk_s1_r, sclk_s2_r, sclk_d_r, din_s1_r, din_s2_r;
  logic dem_s1_r, dem_s2_r, car_s1_r, car_s2_r;
  logic sclk_rise, sclk_fall, spi_mode;
  logic [8:0] cfg_r [CFG_ROWS];
  logic parity_err_r;
  logic [TMR_W-1:0] alarm_cnt_r, settle_cnt_r, oe_cnt_r;
  logic alarm_exp_r, settle_done_r, oe_open_r, inact_flag_r;
  logic tx_bit_r, rx_bit_r, rx_valid_r, demod_data_out, carrier_square_out;

  // Reset is released through two flops.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_int_n = rst_sync_r[1];

  // Two-flop synchronisers for every pin and analog input.
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      {cs_s1_r, cs_s2_r} <= 2'h3;
      {sclk_s1_r, sclk_s2_r, sclk_d_r} <= 3'h0;
      {din_s1_r, din_s2_r} <= 2'h0;
      {dem_s1_r, dem_s2_r, car_s1_r, car_s2_r} <= 4'h0;
    end else if (clk_en) begin
      cs_s1_r <= chip_sel_n_pin;
      cs_s2_r <= cs_s1_r;
      sclk_s1_r <= sclk_alert_i;
      sclk_s2_r <= sclk_s1_r;
      sclk_d_r <= sclk_s2_r;
      din_s1_r <= data_pin_i;
      din_s2_r <= din_s1_r;
      dem_s1_r <= demod_raw;
      dem_s2_r <= dem_s1_r;
      car_s1_r <= carrier_raw;
      car_s2_r <= car_s1_r;
    end
  end

  // Low chip select is programming mode, high is receive mode.
  assign spi_mode = !cs_s2_r;
  assign recv_mode = cs_s2_r;
  // The shared clock pin is only a clock in programming mode.
  assign sclk_rise = spi_mode && sclk_s2_r && !sclk_d_r;
  assign sclk_fall = spi_mode && !sclk_s2_r && sclk_d_r;

  // Configuration rows; each row must keep odd parity over its nine bits.
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      for (int i = 0; i < CFG_ROWS; i++) begin
        cfg_r[i] <= CFG_ROW_RST;
      end
      parity_err_r <= 1'b0;
    end else if (clk_en) begin
      if (cfg_wr) begin
        cfg_r[cfg_wr_idx] <= cfg_wr_data;
      end
      parity_err_r <= 1'b0;
      for (int i = 0; i < CFG_ROWS; i++) begin
        if (!(^cfg_r[i])) begin
          parity_err_r <= 1'b1;
        end
      end
    end
  end
  assign parity_err = parity_err_r;

  // Alarm timer runs in receive mode and restarts whenever the controller selects.
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      alarm_cnt_r <= TMR_ZERO;
      alarm_exp_r <= 1'b0;
    end else if (clk_en) begin
      if (spi_mode) begin
        alarm_cnt_r <= TMR_ZERO;
        alarm_exp_r <= 1'b0;
      end else if (alarm_cnt_r == TMR_W'(ALARM_CYCLES - 1)) begin
        alarm_exp_r <= 1'b1;
      end else begin
        alarm_cnt_r <= alarm_cnt_r + 1'b1;
      end
    end
  end
  assign alarm_expired = alarm_exp_r;

  // Alert is open collector: value is always low, only the enable moves.
  assign sclk_alert_o = 1'b0;
  assign sclk_alert_oe = recv_mode && (parity_err_r || alarm_exp_r);

  // Gain settle counter starts on each entry to receive mode.
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      settle_cnt_r <= TMR_ZERO;
      settle_done_r <= 1'b0;
    end else if (clk_en) begin
      if (spi_mode) begin
        settle_cnt_r <= TMR_ZERO;
        settle_done_r <= 1'b0;
      end else if (settle_cnt_r == TMR_W'(SETTLE_CYCLES - 1)) begin
        settle_done_r <= 1'b1;
      end else begin
        settle_cnt_r <= settle_cnt_r + 1'b1;
      end
    end
  end

  // Output enable filter opens after a long enough high and shuts on inactivity.
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      oe_cnt_r <= TMR_ZERO;
      oe_open_r <= 1'b0;
    end else if (clk_en) begin
      if (spi_mode || inact_expired || !oe_filter_en) begin
        oe_cnt_r <= TMR_ZERO;
        oe_open_r <= 1'b0;
      end else if (!dem_s2_r) begin
        oe_cnt_r <= TMR_ZERO;
      end else if (oe_cnt_r == TMR_W'(OE_HIGH_CYCLES - 1)) begin
        oe_open_r <= 1'b1;
      end else begin
        oe_cnt_r <= oe_cnt_r + 1'b1;
      end
    end
  end

  // Inactivity indication latches only with the filter off; a new expiry beats the clear.
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      inact_flag_r <= 1'b0;
    end else if (clk_en) begin
      if (inact_expired && !oe_filter_en) begin
        inact_flag_r <= 1'b1;
      end else if (spi_mode || oe_filter_en) begin
        inact_flag_r <= 1'b0;
      end
    end
  end

  // Serial data: bits taken on clock rises, read data changes on clock falls.
  always_ff @(posedge core_clk or negedge rst_int_n) begin
    if (!rst_int_n) begin
      rx_bit_r <= 1'b0;
      rx_valid_r <= 1'b0;
      tx_bit_r <= 1'b0;
    end else if (clk_en) begin
      rx_valid_r <= sclk_rise;
      if (sclk_rise) begin
        rx_bit_r <= din_s2_r;
      end
      if (sclk_fall || !spi_mode) begin
        tx_bit_r <= serial_tx_bit;
      end
    end
  end
  assign serial_rx_bit = rx_bit_r;
  assign serial_rx_valid = rx_valid_r;

  // Receive mode data sources.
  assign demod_data_out = (dem_s2_r && (!oe_filter_en || oe_open_r)) || inact_flag_r;
  assign carrier_square_out = car_s2_r && settle_done_r;

  // Data pin: receive output while chip select is high, serial data otherwise.
  always_comb begin
    data_pin_o = 1'b0;
    data_pin_oe = 1'b0;
    if (recv_mode) begin
      data_pin_oe = 1'b1;
      case (out_type_sel)
        LFP_OUT_DEMOD: data_pin_o = demod_data_out;
        LFP_OUT_CARRIER: data_pin_o = carrier_square_out;
        default: data_pin_o = 1'b0;
      endcase
    end else begin
      data_pin_o = tx_bit_r;
      data_pin_oe = serial_tx_en;
    end
  end

  // Signal strength sink follows its output option.
  assign signal_strength_out = recv_mode && (out_type_sel == LFP_OUT_STRENGTH);

  // Checks.
  alert_src_a: assert property (@(posedge core_clk) disable iff (!rst_int_n)
    sclk_alert_oe |-> (parity_err || alarm_expired) && recv_mode)
    else $error("alert pulled without cause");
  alert_low_a: assert property (@(posedge core_clk) disable iff (!rst_int_n)
    sclk_alert_o == 1'b0) else $error("alert driven high");
  alert_mode_a: assert property (@(posedge core_clk) disable iff (!rst_int_n)
    spi_mode |-> !sclk_alert_oe) else $error("alert driven during programming");
  data_drive_a: assert property (@(posedge core_clk) disable iff (!rst_int_n)
    recv_mode |-> data_pin_oe) else $error("data pin not driven in receive mode");
  cs_release_a: assert property (@(posedge core_clk) disable iff (!rst_int_n)
    (spi_mode && !serial_tx_en) |-> !data_pin_oe) else $error("data pin held in programming");
  carrier_gate_a: assert property (@(posedge core_clk) disable iff (!rst_int_n)
    (recv_mode && !settle_done_r && out_type_sel == LFP_OUT_CARRIER) |-> !data_pin_o)
    else $error("carrier before settle");
  settle_time_a: assert property (@(posedge core_clk) disable iff (!rst_int_n)
    $rose(settle_done_r) |-> settle_cnt_r == TMR_W'(SETTLE_CYCLES - 1))
    else $error("settle time wrong");
  strength_opt_a: assert property (@(posedge core_clk) disable iff (!rst_int_n)
    signal_strength_out |-> recv_mode && out_type_sel == LFP_OUT_STRENGTH)
    else $error("strength sink without option");
  inact_filter_a: assert property (@(posedge core_clk) disable iff (!rst_int_n)
    (oe_filter_en && clk_en) |=> !inact_flag_r) else $error("inactivity shown with filter");
  filter_block_a: assert property (@(posedge core_clk) disable iff (!rst_int_n)
    (oe_filter_en && !oe_open_r && !inact_flag_r) |-> !demod_data_out)
    else $error("filtered data leaked");
  rx_take_a: assert property (@(posedge core_clk) disable iff (!rst_int_n)
    (sclk_rise && clk_en) |=> serial_rx_valid && serial_rx_bit == $past(din_s2_r))
    else $error("serial bit not taken");
  parity_a: assert property (@(posedge core_clk) disable iff (!rst_int_n)
    (clk_en && !(^cfg_r[0])) |=> parity_err) else $error("parity error missed");

  alert_cov_c: cover property (@(posedge core_clk) disable iff (!rst_int_n) $rose(sclk_alert_oe));
  carrier_cov_c: cover property (@(posedge core_clk) disable iff (!rst_int_n)
    settle_done_r && out_type_sel == LFP_OUT_CARRIER && data_pin_o);
  filter_cov_c: cover property (@(posedge core_clk) disable iff (!rst_int_n) $rose(oe_open_r));
  serial_cov_c: cover property (@(posedge core_clk) disable iff (!rst_int_n) serial_rx_valid);

endmodule

//--- testbench/lfp_mcu_model.sv
/*
  Serial master model at the far side of the shared pins.
  Assumes the bench resolves the pin levels from these outputs.
*/
`timescale 1ns/1ps
module lfp_mcu_model (
  input wire logic core_clk, // Core clock, used only to start frames.
  output logic cs_n, // Chip select, active low.
  output logic sclk, // Serial clock, still outside frames.
  output logic sdo, // Serial data towards the device.
  output logic sdo_oe // High while the model drives the data line.
);
  // Idle with chip select high so the device keeps receiving.
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdo = 1'b0;
    sdo_oe = 1'b0;
  end

  // One four-bit frame at an 800 ns link period; rd leaves the line to the device.
  // Chip select then stays high for 500 ns, so the device sees receive mode again.
  task automatic frame(input logic [3:0] b, input logic rd);
    @(posedge core_clk);
    #37 cs_n = 1'b0;
    #500;
    for (int i = 3; i >= 0; i--) begin
      sdo_oe = !rd;
      sdo = rd ? !sdo : b[i];
      #400 sclk = 1'b1;
      #400 sclk = 1'b0;
    end
    sdo_oe = 1'b0;
    sdo = !sdo;
    #300 cs_n = 1'b1;
    #500;
  endtask
endmodule

//--- testbench/lfp_shared_pin_ctrl_tb.sv
/*
  Self-checking bench for the shared pin control.
  Assumes shortened timer parameters and a serial master model on the pins.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin fails++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module lfp_shared_pin_ctrl_tb;
  import lfp_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, demod_raw = 1'b0, carrier_raw = 1'b0;
  logic oe_filter_en = 1'b0, inact_expired = 1'b0, cfg_wr = 1'b0;
  logic serial_tx_en = 1'b0, serial_tx_bit = 1'b0, clk_en = 1'b1;
  logic [2:0] cfg_wr_idx = 3'h0;
  logic [8:0] cfg_wr_data = 9'h100;
  lfp_out_type_t out_type_sel = LFP_OUT_DEMOD;
  logic sclk_alert_o, sclk_alert_oe, data_pin_o, data_pin_oe, serial_rx_bit, serial_rx_valid;
  logic signal_strength_out, parity_err, alarm_expired, recv_mode;
  logic cs_n, sclk, sdo, sdo_oe, alert_line, data_line;
  logic [3:0] rx_q = 4'h0;
  int rx_cnt = 0, fails = 0, n_compared = 0;

  // Pin levels: the alert pin is pulled up when nobody pulls it low.
  assign alert_line = !cs_n ? sclk : (sclk_alert_oe ? sclk_alert_o : 1'b1);
  assign data_line = data_pin_oe ? data_pin_o : sdo;

  // Clock at 10 MHz.
  always #50 core_clk = !core_clk;

  // Collects serial bits taken in by the device.
  always @(posedge core_clk) begin
    if (serial_rx_valid === 1'b1) begin
      rx_q <= {rx_q[2:0], serial_rx_bit};
      rx_cnt <= rx_cnt + 1;
    end
  end

  lfp_mcu_model mcu (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk), .sdo(sdo), .sdo_oe(sdo_oe));

  lfp_shared_pin_ctrl #(.ALARM_CYCLES(400), .SETTLE_CYCLES(20), .OE_HIGH_CYCLES(10)) uut (
    .core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en), .chip_sel_n_pin(cs_n),
    .sclk_alert_i(alert_line), .sclk_alert_o(sclk_alert_o), .sclk_alert_oe(sclk_alert_oe),
    .data_pin_i(data_line), .data_pin_o(data_pin_o), .data_pin_oe(data_pin_oe),
    .demod_raw(demod_raw), .carrier_raw(carrier_raw), .out_type_sel(out_type_sel),
    .oe_filter_en(oe_filter_en), .inact_expired(inact_expired), .cfg_wr(cfg_wr),
    .cfg_wr_idx(cfg_wr_idx), .cfg_wr_data(cfg_wr_data), .serial_tx_en(serial_tx_en),
    .serial_tx_bit(serial_tx_bit), .serial_rx_bit(serial_rx_bit),
    .serial_rx_valid(serial_rx_valid), .signal_strength_out(signal_strength_out),
    .parity_err(parity_err), .alarm_expired(alarm_expired), .recv_mode(recv_mode));

  // Waits n edges and lets their updates land.
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Writes one configuration row.
  task automatic wr(input logic [2:0] idx, input logic [8:0] d);
    cfg_wr <= 1'b1;
    cfg_wr_idx <= idx;
    cfg_wr_data <= d;
    step(1);
    cfg_wr <= 1'b0;
    step(3);
  endtask

  // Pulses the inactivity expiry and checks the data pin.
  task automatic inact(input logic filt, input logic ex);
    oe_filter_en <= filt;
    inact_expired <= 1'b1;
    step(1);
    inact_expired <= 1'b0;
    step(3);
    `CHK("inact data", ex, data_pin_o);
  endtask

  // Reset state, then carrier held back until gain settling ends, frozen by the enable.
  task automatic t_reset_carrier();
    `CHK("recv_mode", 1'b1, recv_mode);
    `CHK("alert_o", 1'b0, sclk_alert_o);
    `CHK("alert line idle", 1'b1, alert_line);
    step(1);
    rst_n <= 1'b1;
    step(2);
    out_type_sel <= LFP_OUT_CARRIER;
    carrier_raw <= 1'b1;
    step(4);
    `CHK("carrier early", 1'b0, data_pin_o);
    clk_en <= 1'b0;
    step(30);
    `CHK("carrier frozen", 1'b0, data_pin_o);
    clk_en <= 1'b1;
    step(20);
    `CHK("carrier", 1'b1, data_pin_o);
    carrier_raw <= 1'b0;
    step(4);
    `CHK("carrier low", 1'b0, data_line);
  endtask

  // Strength sink, direct demod and the output enable filter.
  task automatic t_outputs();
    out_type_sel <= LFP_OUT_STRENGTH;
    step(2);
    `CHK("strength on", 1'b1, signal_strength_out);
    `CHK("strength pin", 1'b0, data_pin_o);
    out_type_sel <= LFP_OUT_DEMOD;
    demod_raw <= 1'b1;
    step(4);
    `CHK("strength off", 1'b0, signal_strength_out);
    `CHK("demod direct", 1'b1, data_line);
    demod_raw <= 1'b0;
    oe_filter_en <= 1'b1;
    step(4);
    demod_raw <= 1'b1;
    step(5);
    `CHK("filter closed", 1'b0, data_pin_o);
    step(12);
    `CHK("filter open", 1'b1, data_pin_o);
    demod_raw <= 1'b0;
    step(4);
    inact(1'b1, 1'b0);
    inact(1'b0, 1'b1);
    oe_filter_en <= 1'b1;
    step(3);
    `CHK("inact cleared", 1'b0, data_pin_o);
    oe_filter_en <= 1'b0;
  endtask

  // Bad row parity, then write and read frames, then the alarm timer.
  task automatic t_serial();
    wr(3'h3, 9'h003);
    `CHK("parity bad", 1'b1, parity_err);
    `CHK("alert low", 1'b0, alert_line);
    fork
      mcu.frame(4'ha, 1'b0);
      begin
        step(5);
        `CHK("prog mode", 1'b0, recv_mode);
        `CHK("data released", 1'b0, data_pin_oe);
        `CHK("alert off", 1'b0, sclk_alert_oe);
      end
    join
    `CHK("rx count", 4, rx_cnt);
    `CHK("rx bits", 4'ha, rx_q);
    // Read data is requested only once the device has left the line in programming mode.
    fork
      mcu.frame(4'h0, 1'b1);
      begin
        step(5);
        `CHK("tx idle oe", 1'b0, data_pin_oe);
        serial_tx_en <= 1'b1;
        serial_tx_bit <= 1'b1;
        step(15);
        `CHK("tx oe", 1'b1, data_pin_oe);
        `CHK("tx bit", 1'b1, data_line);
        serial_tx_en <= 1'b0;
      end
    join
    wr(3'h3, 9'h103);
    wr(3'h0, 9'h007);
    `CHK("parity good", 1'b0, parity_err);
    step(290);
    `CHK("alarm early", 1'b0, alarm_expired);
    `CHK("alert idle", 1'b1, alert_line);
    step(120);
    `CHK("alarm", 1'b1, alarm_expired);
    `CHK("alarm alert", 1'b0, alert_line);
  endtask

  // Main sequence: reset held for three cycles, released inside the first scenario.
  initial begin
    step(2);
    t_reset_carrier();
    t_outputs();
    t_serial();
    summarize();
  end
endmodule
